// *** hw/cetc_consts.svh ***
// Register offsets, field positions, opcodes and reset values
`ifndef CETC_CONSTS_SVH
`define CETC_CONSTS_SVH
`define CETC_OFS_STATUS_SEL 12'h01D
`define CETC_BIT_STATUS_SEL 7
`define CETC_OFS_APPLY 12'h232
`define CETC_BIT_APPLY 0
`define CETC_OFS_SEG_BASE 12'hA00
`define CETC_OFS_SEG_LAST 12'hA16
`define CETC_SEG_ENTRIES 23
`define CETC_OFS_XFER_STATUS 12'hB00
`define CETC_OFS_XFER_ERROR 12'hB01
`define CETC_OFS_RESTORE 12'hB02
`define CETC_BIT_WR_EN 0
`define CETC_BIT_SOFT_RESTORE 1
`define CETC_OFS_STORE_TRIG 12'hB03
`define CETC_BIT_STORE_TRIG 0
`define CETC_OP_UPDATE 8'h80
`define CETC_OP_END 8'hFF
`define CETC_SEG_ADDR_RST 8'h00
`define CETC_BYTE_RST 8'h00
`endif

// *** hw/cetc_pkg.sv ***
// Types shared by the configuration transfer controller
package cetc_pkg;
  typedef logic [7:0] cetc_byte_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_XFER,
    ST_DRAIN
  } cetc_state_e;
endpackage : cetc_pkg

// *** hw/cetc_top.sv ***
// Configuration transfer controller: buffer, active bank, store walker
`include "cetc_consts.svh"
module cetc_top #(
  parameter int BUF_DEPTH = 16,
  parameter int FIFO_DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input wire logic store_sel_b,
  output logic status_pin_q,
  output logic soft_reset_q,
  output logic [BUF_DEPTH*8-1:0] cfg_active_q,
  output logic nvm_tx_valid_q,
  output logic [7:0] nvm_tx_data_q,
  input wire logic nvm_tx_ready,
  input wire logic nvm_rx_valid,
  input wire logic [7:0] nvm_rx_data,
  input wire logic nvm_rx_err,
  output logic nvm_rx_ready_q
);
  localparam int BAW = $clog2(BUF_DEPTH);
  localparam int FAW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int FCW = $clog2(FIFO_DEPTH + 1);
  localparam logic [4:0] ENTRIES = 5'(`CETC_SEG_ENTRIES);
  localparam logic [11:0] BUF_END = 12'(BUF_DEPTH);
  localparam logic [FCW-1:0] FIFO_FULL = FCW'(FIFO_DEPTH);
  cetc_pkg::cetc_byte_t buf_q [BUF_DEPTH];
  cetc_pkg::cetc_byte_t seg_q [`CETC_SEG_ENTRIES];
  cetc_pkg::cetc_byte_t fifo_q [FIFO_DEPTH];
  cetc_pkg::cetc_state_e state_q, state_d;
  logic [BUF_DEPTH*8-1:0] buf_flat;
  logic [4:0] idx_q, idx_d;
  logic [6:0] cnt_q, cnt_d;
  logic [11:0] addr_q, addr_d;
  logic [FAW-1:0] wr_ptr_q, rd_ptr_q, rd_ptr_d;
  logic [FCW-1:0] fcnt_q, fcnt_d;
  logic restore_q, upd_q, soft_q, wr_en_q, trig_q, err_q, status_sel_q;
  logic op_upd, push, take, fin, pop, do_copy, idle, host_wr;
  logic start_save, start_restore;
  cetc_pkg::cetc_byte_t code, push_data, rd_d;

  // ****************************************************************
  // Host decode
  // ****************************************************************
  assign idle = (state_q == cetc_pkg::ST_IDLE);
  // Host writes to buffer and table are held off while the walker owns them
  assign host_wr = reg_wr_stb && idle;
  assign start_save = idle && !soft_q && wr_en_q && reg_wr_stb &&
      reg_addr == `CETC_OFS_STORE_TRIG && reg_wdata[`CETC_BIT_STORE_TRIG];
  assign start_restore = idle && soft_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= reg_wr_stb && reg_addr == `CETC_OFS_APPLY &&
          reg_wdata[`CETC_BIT_APPLY];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      soft_q <= 1'b0;
      soft_reset_q <= 1'b0;
      wr_en_q <= 1'b0;
      status_sel_q <= 1'b0;
    end else begin
      soft_q <= reg_wr_stb && reg_addr == `CETC_OFS_RESTORE &&
          reg_wdata[`CETC_BIT_SOFT_RESTORE] && !store_sel_b;
      soft_reset_q <= start_restore;
      if (reg_wr_stb && reg_addr == `CETC_OFS_RESTORE) begin
        wr_en_q <= reg_wdata[`CETC_BIT_WR_EN];
      end
      if (reg_wr_stb && reg_addr == `CETC_OFS_STATUS_SEL) begin
        status_sel_q <= reg_wdata[`CETC_BIT_STATUS_SEL];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trig_q <= 1'b0;
    end else if (start_save) begin
      trig_q <= 1'b1;
    end else if (fin) begin
      trig_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Segment table, buffer bank and active bank
  // ****************************************************************
  assign do_copy = upd_q || op_upd;
  generate
    for (genvar i = 0; i < `CETC_SEG_ENTRIES; i++) begin : g_seg
      localparam cetc_pkg::cetc_byte_t RST =
          (i == 0) ? 8'(BUF_DEPTH - 1) :
          (i < 3) ? `CETC_SEG_ADDR_RST :
          (i == 3) ? `CETC_OP_UPDATE : `CETC_OP_END;
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          seg_q[i] <= RST;
        end else if (host_wr && reg_addr == `CETC_OFS_SEG_BASE + 12'(i)) begin
          seg_q[i] <= reg_wdata;
        end
      end
    end
    for (genvar j = 0; j < BUF_DEPTH; j++) begin : g_buf
      assign buf_flat[j*8 +: 8] = buf_q[j];
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          buf_q[j] <= `CETC_BYTE_RST;
        end else if (take && addr_q == 12'(j)) begin
          buf_q[j] <= nvm_rx_data;
        end else if (host_wr && reg_addr == 12'(j)) begin
          buf_q[j] <= reg_wdata;
        end
      end
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          cfg_active_q[j*8 +: 8] <= `CETC_BYTE_RST;
        end else if (do_copy) begin
          cfg_active_q[j*8 +: 8] <= buf_q[j];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Segment walker
  // ****************************************************************
  assign code = (idx_q < ENTRIES) ? seg_q[idx_q] : `CETC_OP_END;
  assign push_data = (addr_q < BUF_END) ? buf_q[addr_q[BAW-1:0]] :
      `CETC_BYTE_RST;
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    op_upd = 1'b0;
    push = 1'b0;
    take = 1'b0;
    fin = 1'b0;
    unique case (state_q)
      cetc_pkg::ST_IDLE: begin
        if (start_save || start_restore) begin
          state_d = cetc_pkg::ST_FETCH;
          idx_d = 5'h00;
        end
      end
      cetc_pkg::ST_FETCH: begin
        if (code == `CETC_OP_END || idx_q + 5'h02 >= ENTRIES &&
            code != `CETC_OP_UPDATE) begin
          state_d = cetc_pkg::ST_DRAIN;
        end else if (code == `CETC_OP_UPDATE) begin
          op_upd = 1'b1;
          idx_d = idx_q + 5'h01;
        end else begin
          cnt_d = code[6:0];
          addr_d = {seg_q[idx_q + 5'h01][3:0], seg_q[idx_q + 5'h02]};
          idx_d = idx_q + 5'h03;
          state_d = cetc_pkg::ST_XFER;
        end
      end
      cetc_pkg::ST_XFER: begin
        // Save stalls on a full buffer so no byte is dropped
        push = !restore_q && fcnt_q != FIFO_FULL;
        take = restore_q && nvm_rx_valid && nvm_rx_ready_q;
        if (push || take) begin
          addr_d = addr_q + 12'h001;
          if (cnt_q == 7'h00) begin
            state_d = cetc_pkg::ST_FETCH;
          end else begin
            cnt_d = cnt_q - 7'h01;
          end
        end
      end
      cetc_pkg::ST_DRAIN: begin
        if (fcnt_q == {FCW{1'b0}}) begin
          fin = 1'b1;
          state_d = cetc_pkg::ST_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= cetc_pkg::ST_IDLE;
      idx_q <= 5'h00;
      cnt_q <= 7'h00;
      addr_q <= 12'h000;
      restore_q <= 1'b0;
      nvm_rx_ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      if (start_save || start_restore) begin
        restore_q <= start_restore;
      end
      nvm_rx_ready_q <= state_d == cetc_pkg::ST_XFER && restore_q;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      err_q <= 1'b0;
    end else if (take && nvm_rx_err) begin
      err_q <= 1'b1;
    end else if (start_save || start_restore) begin
      err_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      status_pin_q <= 1'b0;
    end else begin
      status_pin_q <= status_sel_q && state_d != cetc_pkg::ST_IDLE;
    end
  end

  // ****************************************************************
  // Two-entry save buffer
  // ****************************************************************
  assign pop = nvm_tx_valid_q && nvm_tx_ready;
  assign fcnt_d = fcnt_q + FCW'(push) - FCW'(pop);
  assign rd_ptr_d = pop ? FAW'((32'(rd_ptr_q) + 1) % FIFO_DEPTH) : rd_ptr_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= {FAW{1'b0}};
      rd_ptr_q <= {FAW{1'b0}};
      fcnt_q <= {FCW{1'b0}};
      nvm_tx_valid_q <= 1'b0;
      nvm_tx_data_q <= `CETC_BYTE_RST;
    end else begin
      if (push) begin
        fifo_q[wr_ptr_q] <= push_data;
        wr_ptr_q <= FAW'((32'(wr_ptr_q) + 1) % FIFO_DEPTH);
      end
      rd_ptr_q <= rd_ptr_d;
      fcnt_q <= fcnt_d;
      nvm_tx_valid_q <= fcnt_d != {FCW{1'b0}};
      // The head is the fresh byte when the buffer would otherwise run dry
      if (push && fcnt_q - FCW'(pop) == {FCW{1'b0}}) begin
        nvm_tx_data_q <= push_data;
      end else if (fcnt_d != {FCW{1'b0}}) begin
        nvm_tx_data_q <= fifo_q[rd_ptr_d];
      end
    end
  end

  // ****************************************************************
  // Readback
  // ****************************************************************
  // buffer, segment table and status register readback
  always_comb begin
    rd_d = 8'h00;
    if (reg_addr < BUF_END) begin
      rd_d = buf_q[reg_addr[BAW-1:0]];
    end else if (reg_addr >= `CETC_OFS_SEG_BASE &&
        reg_addr <= `CETC_OFS_SEG_LAST) begin
      rd_d = seg_q[5'(reg_addr - `CETC_OFS_SEG_BASE)];
    end else if (reg_addr == `CETC_OFS_STATUS_SEL) begin
      rd_d = {status_sel_q, 7'h00};
    end else if (reg_addr == `CETC_OFS_XFER_STATUS) begin
      rd_d = {7'h00, !idle};
    end else if (reg_addr == `CETC_OFS_XFER_ERROR) begin
      rd_d = {7'h00, err_q};
    end else if (reg_addr == `CETC_OFS_RESTORE) begin
      rd_d = {6'h00, soft_q, wr_en_q};
    end else if (reg_addr == `CETC_OFS_STORE_TRIG) begin
      rd_d = {7'h00, trig_q};
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd_stb;
      if (reg_rd_stb) begin
        reg_rdata_q <= rd_d;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_apply_copy: assert property (
    upd_q |=> cfg_active_q == $past(buf_flat)) else $error("no apply copy");
  chk_apply_clear: assert property (
    upd_q && !(reg_wr_stb && reg_addr == `CETC_OFS_APPLY) |=> !upd_q)
    else $error("apply bit did not clear");
  chk_end_opcode: assert property (
    state_q == cetc_pkg::ST_FETCH && code == `CETC_OP_END |=>
    state_q == cetc_pkg::ST_DRAIN) else $error("end opcode ignored");
  chk_busy_read: assert property (
    reg_rd_stb && reg_addr == `CETC_OFS_XFER_STATUS |=>
    reg_rdata_q == {7'h00, $past(!idle)}) else $error("busy read wrong");
  chk_status_pin: assert property (
    status_pin_q == ($past(status_sel_q) && !idle))
    else $error("status pin does not follow busy");
  chk_err_set: assert property (
    take && nvm_rx_err |=> err_q ##1 (err_q || !idle))
    else $error("error bit missed bad data");
  chk_soft_start: assert property (
    soft_q && idle |=> state_q == cetc_pkg::ST_FETCH && restore_q &&
    soft_reset_q) else $error("soft restore did not start");
  chk_soft_clear: assert property (
    soft_q && !(reg_wr_stb && reg_addr == `CETC_OFS_RESTORE) |=> !soft_q)
    else $error("soft restore bit stuck");
  chk_protect_gate: assert property (
    !wr_en_q && idle && !trig_q |=> !trig_q) else $error("protected trigger");
  chk_trig_hold: assert property (
    trig_q && !idle |=> trig_q || $past(fin)) else $error("trigger dropped");
  chk_err_clear: assert property (
    idle ##1 state_q == cetc_pkg::ST_FETCH |-> !err_q)
    else $error("error flag not cleared at start");
  chk_fifo_stall: assert property (
    nvm_tx_valid_q && !nvm_tx_ready |=>
    nvm_tx_valid_q && $stable(nvm_tx_data_q)) else $error("save byte lost");
  cov_save_done: cover property (trig_q ##1 !trig_q);
  cov_restore_done: cover property (restore_q && fin);
  cov_fifo_full: cover property (fcnt_q == FIFO_FULL);
  cov_apply: cover property (upd_q);
endmodule : cetc_top

// *** testbench/cetc_store_model.sv ***
// Behavioural nonvolatile store on the save and restore streams
module cetc_store_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic soft_reset_q,
  input wire logic nvm_tx_valid_q,
  input wire logic [7:0] nvm_tx_data_q,
  output logic nvm_tx_ready,
  output logic nvm_rx_valid,
  output logic [7:0] nvm_rx_data,
  output logic nvm_rx_err,
  input wire logic nvm_rx_ready_q,
  input wire logic [4:0] err_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [16];
  logic [3:0] wr_q;
  logic [4:0] rd_q;
  logic [1:0] tick_q;
  logic [7:0] last_q;
  // Stall one cycle in three so the device buffer fills
  assign nvm_tx_ready = tick_q != 2'h2;
  // Idle data lines show the inverse of the last byte, never a held copy
  assign nvm_rx_data = nvm_rx_valid ? mem[rd_q[3:0]] : ~last_q;
  assign nvm_rx_err = nvm_rx_valid && rd_q == err_idx;
  always_ff @(posedge clk_sys) begin
    if (nvm_tx_valid_q && nvm_tx_ready) begin
      mem[wr_q] <= nvm_tx_data_q;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= 4'h0;
      tick_q <= 2'h0;
    end else begin
      tick_q <= (tick_q == 2'h2) ? 2'h0 : tick_q + 2'h1;
      if (nvm_tx_valid_q && nvm_tx_ready) begin
        wr_q <= wr_q + 4'h1;
      end
    end
  end
  // A restore stream restarts at each soft reset; gap after every byte
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= 5'h10;
      nvm_rx_valid <= 1'b0;
      last_q <= 8'h00;
    end else if (soft_reset_q) begin
      rd_q <= 5'h00;
      nvm_rx_valid <= 1'b0;
    end else if (nvm_rx_valid && nvm_rx_ready_q) begin
      rd_q <= rd_q + 5'h01;
      nvm_rx_valid <= 1'b0;
      last_q <= nvm_rx_data;
    end else if (rd_q < 5'h10) begin
      nvm_rx_valid <= 1'b1;
    end
  end
endmodule : cetc_store_model

// *** testbench/config_eeprom_transfer_control_test.sv ***
// Self-checking bench for the configuration transfer controller
module config_eeprom_transfer_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_b, reg_wr_stb, reg_rd_stb, store_sel_b, reg_rvalid_q;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q, nvm_tx_data_q, nvm_rx_data, d;
  logic status_pin_q, soft_reset_q, nvm_tx_valid_q, nvm_tx_ready;
  logic nvm_rx_valid, nvm_rx_err, nvm_rx_ready_q, seen_busy, seen_pin;
  logic [127:0] cfg_active_q;
  logic [4:0] err_idx;
  logic [7:0] exp_buf [16];
  logic [7:0] saved [16];
  logic [7:0] rst_tbl [5] = '{8'h0F, 8'h00, 8'h00, 8'h80, 8'hFF};
  int n_mismatch, compares, n_tx, n_soft;
  cetc_top #(.BUF_DEPTH(16), .FIFO_DEPTH(2)) cetc_top_inst (.clk_sys,
    .rst_b, .reg_wr_stb, .reg_rd_stb, .reg_addr, .reg_wdata, .reg_rdata_q,
    .reg_rvalid_q, .store_sel_b, .status_pin_q, .soft_reset_q,
    .cfg_active_q, .nvm_tx_valid_q, .nvm_tx_data_q, .nvm_tx_ready,
    .nvm_rx_valid, .nvm_rx_data, .nvm_rx_err, .nvm_rx_ready_q);
  cetc_store_model cetc_store_model_inst (.clk_sys, .rst_b, .soft_reset_q,
    .nvm_tx_valid_q, .nvm_tx_data_q, .nvm_tx_ready, .nvm_rx_valid,
    .nvm_rx_data, .nvm_rx_err, .nvm_rx_ready_q, .err_idx);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (nvm_tx_valid_q === 1'b1 && nvm_tx_ready === 1'b1) n_tx++;
    if (soft_reset_q === 1'b1) n_soft++;
    if (status_pin_q === 1'b1) seen_pin = 1'b1;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out();
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [7:0] v);
    @(negedge clk_sys);
    reg_wr_stb = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk_sys);
    reg_wr_stb = 1'b0;
  endtask : wr
  task automatic rd(logic [11:0] a);
    @(negedge clk_sys);
    reg_rd_stb = 1'b1;
    reg_addr = a;
    // The valid flag stands one cycle only, so check it before the next edge
    @(negedge clk_sys);
    chk("rvalid", 1, reg_rvalid_q);
    d = reg_rdata_q;
    reg_rd_stb = 1'b0;
  endtask : rd
  task automatic rdc(logic [11:0] a, logic [7:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, d);
  endtask : rdc
  // Polls the status byte; a transfer that never ends cuts the run short
  task automatic wait_idle();
    seen_busy = 1'b0;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 300; i++) begin
      rd(12'hB00);
      if (d[0] === 1'b0) return;
      seen_busy = 1'b1;
    end
    chk("wait", 0, 1);
    close_out();
  endtask : wait_idle
  function automatic logic [127:0] pack(logic [7:0] b [16]);
    logic [127:0] p;
    for (int i = 0; i < 16; i++) p[i*8+:8] = b[i];
    return p;
  endfunction : pack
  task automatic load_apply();
    for (int i = 0; i < 16; i++) begin
      exp_buf[i] = 8'($urandom);
      wr(12'(i), exp_buf[i]);
    end
    wr(12'h232, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("active", pack(exp_buf), cfg_active_q);
  endtask : load_apply
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {reg_wr_stb, reg_rd_stb, rst_b} = 3'h0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    store_sel_b = 1'b1;
    err_idx = 5'h1F;
    {n_mismatch, compares, n_tx, n_soft} = '0;
    seen_pin = 1'b0;
    void'($urandom(32'h78a796ed));
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    rdc(12'hB00, 8'h00);
    rdc(12'hB01, 8'h00);
    rdc(12'hB02, 8'h00);
    rdc(12'hB03, 8'h00);
    for (int k = 0; k < 5; k++) rdc(12'hA00 + 12'(k), rst_tbl[k]);
    rdc(12'hA16, 8'hFF);
    wr(12'hA16, 8'h5A);
    rdc(12'hA16, 8'h5A);
    wr(12'hA16, 8'hFF);
    rdc(12'h300, 8'h00);
    load_apply();
    rdc(12'h232, 8'h00);
    load_apply();
    wr(12'hB03, 8'h01);
    repeat (4) @(posedge clk_sys);
    rdc(12'hB03, 8'h00);
    chk("tx count", 0, n_tx);
    wr(12'hB02, 8'h01);
    wr(12'hB03, 8'h01);
    wait_idle();
    chk("busy seen", 1, seen_busy);
    chk("pin", 0, seen_pin);
    rdc(12'hB03, 8'h00);
    chk("tx count", 16, n_tx);
    for (int i = 0; i < 16; i++) begin
      chk("stored", exp_buf[i], cetc_store_model_inst.mem[i]);
    end
    saved = exp_buf;
    wr(12'h01D, 8'h80);
    load_apply();
    wr(12'hB02, 8'h03);
    repeat (8) @(posedge clk_sys);
    chk("soft count", 0, n_soft);
    @(negedge clk_sys);
    store_sel_b = 1'b0;
    wr(12'hB02, 8'h03);
    wait_idle();
    chk("soft count", 1, n_soft);
    chk("pin", 1, seen_pin);
    chk("active", pack(saved), cfg_active_q);
    rdc(12'hB02, 8'h01);
    rdc(12'hB01, 8'h00);
    rdc(12'h005, saved[5]);
    err_idx = 5'h03;
    wr(12'hB02, 8'h03);
    wait_idle();
    rdc(12'hB01, 8'h01);
    wr(12'hB03, 8'h01);
    wait_idle();
    rdc(12'hB01, 8'h00);
    chk("tx count", 32, n_tx);
    close_out();
  end
endmodule : config_eeprom_transfer_control_test
